// ---- rtl/adc_two_wire_setup_slave.sv ----
`timescale 1ns/1ps
module adc_two_wire_setup_slave #(
  parameter logic [6:0] SLAVE_ADDR = adc_setup_pkg::SLAVE_ADDR_DEFAULT
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // bus pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe_n,
  // converter side
  input wire logic signed [8:0] sampleDiff,
  output logic [7:0] resultCode,
  output logic resultTaken,
  // setup and configuration
  output adc_setup_pkg::setup_t setupFields,
  output logic sharedInputRefIsRef,
  output logic [7:0] configByte,
  output logic inputEndedSelect,
  output logic bipolarActive,
  output logic setupWritten,
  output logic configWritten,
  // bus status
  output logic busBusy,
  output logic readActive,
  output logic masterNack
);

  typedef struct packed {
    adc_setup_pkg::busState_t st;
    logic sclQ;
    logic sdaQ;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic rw;
    logic drvLow;
    logic nack;
    logic busy;
    adc_setup_pkg::setup_t setup;
    logic [7:0] cfg;
    logic [7:0] code;
    logic setupPulse;
    logic cfgPulse;
    logic takePulse;
    logic nackPulse;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  adc_setup_pkg::pins_t pinSync;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic bipolarEff;
  logic [7:0] codeNxt;

  // both pins share one synchroniser so their edges stay aligned
  pin_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .asyncIn({sclIn, sdaIn}),
    .syncOut(pinSync)
  );

  // edges and bus conditions from synchronised pins
  assign sclRise = pinSync.scl & ~s_r.sclQ;
  assign sclFall = ~pinSync.scl & s_r.sclQ;
  assign startCond = pinSync.scl & s_r.sclQ & s_r.sdaQ & ~pinSync.sda;
  assign stopCond = pinSync.scl & s_r.sclQ & ~s_r.sdaQ & pinSync.sda;

  // polarity only counts in differential mode
  assign bipolarEff = s_r.setup.polaritySelect
                    & ~s_r.cfg[adc_setup_pkg::CFG_SINGLE_BIT];

  // result coding from the signed difference sample
  always_comb begin
    codeNxt = adc_setup_pkg::CODE_ZERO;
    if (bipolarEff) begin
      // over-range differences clamp to the signed limits
      if (sampleDiff > adc_setup_pkg::SIGNED_HI) begin
        codeNxt = adc_setup_pkg::SIGNED_HI_CODE;
      end else if (sampleDiff < adc_setup_pkg::SIGNED_LO) begin
        codeNxt = adc_setup_pkg::SIGNED_LO_CODE;
      end else begin
        codeNxt = sampleDiff[7:0];
      end
    end else begin
      if (sampleDiff[8]) begin
        codeNxt = adc_setup_pkg::CODE_ZERO;
      end else begin
        codeNxt = sampleDiff[7:0];
      end
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.sclQ = pinSync.scl;
    s_nxt.sdaQ = pinSync.sda;
    s_nxt.code = codeNxt;
    // pulses last one enabled cycle
    s_nxt.setupPulse = 1'b0;
    s_nxt.cfgPulse = 1'b0;
    s_nxt.takePulse = 1'b0;
    s_nxt.nackPulse = 1'b0;

    if (stopCond) begin
      // end of transaction: release the bus
      s_nxt.st = adc_setup_pkg::IDLE;
      s_nxt.busy = 1'b0;
      s_nxt.drvLow = 1'b0;
      s_nxt.nack = 1'b0;
      s_nxt.bitCnt = adc_setup_pkg::BIT_CNT_ZERO;
    end else if (startCond) begin
      // start and repeated start both lead to address phase
      // a start in mid-byte drops the partial byte
      s_nxt.st = adc_setup_pkg::ADDR;
      s_nxt.busy = 1'b1;
      s_nxt.nack = 1'b0;
      s_nxt.drvLow = 1'b0;
      s_nxt.bitCnt = adc_setup_pkg::BIT_CNT_ZERO;
    end else if (sclRise) begin
      case (s_r.st)
        adc_setup_pkg::ADDR,
        adc_setup_pkg::WR_DATA: begin
          s_nxt.shift = {s_r.shift[6:0], pinSync.sda};
          s_nxt.bitCnt = s_r.bitCnt + adc_setup_pkg::BIT_CNT_ONE;
        end
        adc_setup_pkg::RD_DATA: begin
          s_nxt.bitCnt = s_r.bitCnt + adc_setup_pkg::BIT_CNT_ONE;
        end
        adc_setup_pkg::RD_ACK: begin
          // high SDA on the ninth clock is a not-acknowledge
          s_nxt.nack = pinSync.sda;
        end
        default: begin
          s_nxt.shift = s_r.shift;
        end
      endcase
    end else if (sclFall) begin
      case (s_r.st)
        adc_setup_pkg::ADDR: begin
          if (s_r.bitCnt == adc_setup_pkg::BYTE_BITS) begin
            if (s_r.shift[7:1] == SLAVE_ADDR) begin
              s_nxt.rw = s_r.shift[0];
              s_nxt.drvLow = 1'b1;
              s_nxt.st = adc_setup_pkg::ADDR_ACK;
            end else begin
              // not ours: stay off the bus until the next start
              s_nxt.st = adc_setup_pkg::IDLE;
              s_nxt.drvLow = 1'b0;
            end
          end
        end
        adc_setup_pkg::ADDR_ACK: begin
          s_nxt.bitCnt = adc_setup_pkg::BIT_CNT_ZERO;
          if (s_r.rw) begin
            // first result bit goes out right after the ack clock
            s_nxt.st = adc_setup_pkg::RD_DATA;
            s_nxt.shift = s_r.code;
            s_nxt.drvLow = ~s_r.code[7];
            s_nxt.takePulse = 1'b1;
          end else begin
            s_nxt.st = adc_setup_pkg::WR_DATA;
            s_nxt.drvLow = 1'b0;
          end
        end
        adc_setup_pkg::WR_DATA: begin
          if (s_r.bitCnt == adc_setup_pkg::BYTE_BITS) begin
            s_nxt.drvLow = 1'b1;
            s_nxt.st = adc_setup_pkg::WR_ACK;
            // decode before the ack so fields update at the eighth fall
            if (s_r.shift[adc_setup_pkg::SETUP_FLAG_BIT]) begin
              s_nxt.setup.refChoice =
                s_r.shift[adc_setup_pkg::REF_HI_BIT:adc_setup_pkg::REF_LO_BIT];
              s_nxt.setup.extClock = s_r.shift[adc_setup_pkg::CLK_SRC_BIT];
              s_nxt.setup.polaritySelect = s_r.shift[adc_setup_pkg::POL_BIT];
              if (!s_r.shift[adc_setup_pkg::CFG_CLR_N_BIT]) begin
                s_nxt.cfg = adc_setup_pkg::CFG_DEFAULT;
              end
              // bit 0 is not looked at
              s_nxt.setupPulse = 1'b1;
            end else begin
              s_nxt.cfg = s_r.shift;
              s_nxt.cfgPulse = 1'b1;
            end
          end
        end
        adc_setup_pkg::WR_ACK: begin
          // release after the ninth clock, next byte may follow
          s_nxt.drvLow = 1'b0;
          s_nxt.bitCnt = adc_setup_pkg::BIT_CNT_ZERO;
          s_nxt.st = adc_setup_pkg::WR_DATA;
        end
        adc_setup_pkg::RD_DATA: begin
          if (s_r.bitCnt == adc_setup_pkg::BYTE_BITS) begin
            // let the master drive its acknowledge
            s_nxt.drvLow = 1'b0;
            s_nxt.nack = 1'b0;
            s_nxt.st = adc_setup_pkg::RD_ACK;
          end else begin
            s_nxt.drvLow = ~s_r.shift[6];
            s_nxt.shift = {s_r.shift[6:0], 1'b0};
          end
        end
        adc_setup_pkg::RD_ACK: begin
          s_nxt.bitCnt = adc_setup_pkg::BIT_CNT_ZERO;
          if (s_r.nack) begin
            // release SDA so the master can stop or restart
            s_nxt.st = adc_setup_pkg::IDLE;
            s_nxt.drvLow = 1'b0;
            s_nxt.nackPulse = 1'b1;
          end else begin
            s_nxt.st = adc_setup_pkg::RD_DATA;
            s_nxt.shift = s_r.code;
            s_nxt.drvLow = ~s_r.code[7];
            s_nxt.takePulse = 1'b1;
          end
        end
        default: begin
          s_nxt.drvLow = 1'b0;
        end
      endcase
    end
  end

  // reset loads constants only; ce low freezes every field
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r.st <= adc_setup_pkg::IDLE;
      s_r.sclQ <= 1'b1;
      s_r.sdaQ <= 1'b1;
      s_r.bitCnt <= adc_setup_pkg::BIT_CNT_ZERO;
      s_r.shift <= adc_setup_pkg::CODE_ZERO;
      s_r.rw <= 1'b0;
      s_r.drvLow <= 1'b0;
      s_r.nack <= 1'b0;
      s_r.busy <= 1'b0;
      s_r.setup.refChoice <= adc_setup_pkg::REF_RESET;
      s_r.setup.extClock <= adc_setup_pkg::CLK_SRC_RESET;
      s_r.setup.polaritySelect <= adc_setup_pkg::POL_RESET;
      s_r.cfg <= adc_setup_pkg::CFG_DEFAULT;
      s_r.code <= adc_setup_pkg::CODE_ZERO;
      s_r.setupPulse <= 1'b0;
      s_r.cfgPulse <= 1'b0;
      s_r.takePulse <= 1'b0;
      s_r.nackPulse <= 1'b0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // open drain: only ever pulls low; slave only, SCL never driven
  assign sdaOut = 1'b0;
  assign sdaOe_n = ~s_r.drvLow;

  assign resultCode = s_r.code;
  assign resultTaken = s_r.takePulse;
  assign setupFields = s_r.setup;
  assign sharedInputRefIsRef = s_r.setup.refChoice[adc_setup_pkg::REF_PIN_SEL_BIT];
  assign configByte = s_r.cfg;
  assign inputEndedSelect = s_r.cfg[adc_setup_pkg::CFG_SINGLE_BIT];
  assign bipolarActive = bipolarEff;
  assign setupWritten = s_r.setupPulse;
  assign configWritten = s_r.cfgPulse;
  assign busBusy = s_r.busy;
  // read phase covers the data bits and the master's ack slot
  assign readActive = (s_r.st == adc_setup_pkg::RD_DATA)
                    | (s_r.st == adc_setup_pkg::RD_ACK);
  assign masterNack = s_r.nackPulse;

endmodule

// ---- pkg/adc_setup_pkg.sv ----
package adc_setup_pkg;

  // setup byte field layout
  localparam int SETUP_FLAG_BIT = 7;
  localparam int REF_HI_BIT = 6;
  localparam int REF_LO_BIT = 4;
  // reference choice bit that hands the shared pin to the reference
  localparam int REF_PIN_SEL_BIT = 1;
  localparam int CLK_SRC_BIT = 3;
  localparam int POL_BIT = 2;
  localparam int CFG_CLR_N_BIT = 1;

  // configuration byte: position of the input-ended select bit
  localparam int CFG_SINGLE_BIT = 0;

  // power-up values
  localparam logic [2:0] REF_RESET = 3'h0;
  localparam logic CLK_SRC_RESET = 1'h0;
  localparam logic POL_RESET = 1'h0;
  localparam logic [7:0] CFG_DEFAULT = 8'h01;

  // framing
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [3:0] BIT_CNT_ONE = 4'h1;

  // result coding limits
  localparam logic [7:0] CODE_ZERO = 8'h00;
  localparam logic signed [8:0] SIGNED_HI = 9'sh07F;
  localparam logic signed [8:0] SIGNED_LO = 9'sh180;
  localparam logic [7:0] SIGNED_HI_CODE = 8'h7F;
  localparam logic [7:0] SIGNED_LO_CODE = 8'h80;

  // slave address, value arbitrary
  localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h2A;

  typedef enum logic [2:0] {
    IDLE,
    ADDR,
    ADDR_ACK,
    WR_DATA,
    WR_ACK,
    RD_DATA,
    RD_ACK
  } busState_t;

  typedef struct packed {
    logic [2:0] refChoice;
    logic extClock;
    logic polaritySelect;
  } setup_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } pins_t;

endpackage

// ---- rtl/pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } syncState_t;

  syncState_t s_r;
  syncState_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.stage1 = asyncIn;
    s_nxt.stage2 = s_r.stage1;
  end

  // idle bus level is high, so both stages reset high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '1;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign syncOut = s_r.stage2;

endmodule

// ---- bench/adc_setup_monitor.sv ----
`timescale 1ns/1ps
module adc_setup_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // bus pins
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe_n,
  // converter side
  input wire logic signed [8:0] sampleDiff,
  input wire logic [7:0] resultCode,
  input wire logic resultTaken,
  // setup and configuration
  input wire adc_setup_pkg::setup_t setupFields,
  input wire logic sharedInputRefIsRef,
  input wire logic [7:0] configByte,
  input wire logic inputEndedSelect,
  input wire logic bipolarActive,
  input wire logic setupWritten,
  input wire logic configWritten,
  // bus status
  input wire logic busBusy,
  input wire logic readActive,
  input wire logic masterNack
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_idle_release: assert property (!busBusy |-> sdaOe_n) else $error("idle pull");
  a_drive_low: assert property (sdaOut == 1'h0) else $error("sda value");
  a_signed_gate: assert property (
    bipolarActive == (setupFields.polaritySelect && !inputEndedSelect))
    else $error("signed gate");
  a_single_end: assert property (
    inputEndedSelect == configByte[adc_setup_pkg::CFG_SINGLE_BIT])
    else $error("single end");
  a_ref_pin: assert property (sharedInputRefIsRef == setupFields.refChoice[1])
    else $error("ref pin");
  a_unsigned_neg: assert property (
    ce && !bipolarActive && sampleDiff < 0 |=> resultCode == 8'h00)
    else $error("unsigned neg");
  a_unsigned_pass: assert property (ce && !bipolarActive && sampleDiff >= 0
    |=> {1'h0, resultCode} == $past(sampleDiff)) else $error("unsigned code");
  a_signed_clamp: assert property (ce && bipolarActive && sampleDiff > 9'sd127
    |=> resultCode == 8'h7F) else $error("signed clamp");
  a_signed_floor: assert property (ce && bipolarActive && sampleDiff < -9'sd128
    |=> resultCode == 8'h80) else $error("signed floor");
  a_setup_cause: assert property ($changed(setupFields)
    |-> setupWritten || $past(setupWritten)) else $error("setup change");
  a_cfg_cause: assert property ($changed(configByte) |-> configWritten || setupWritten
    || $past(configWritten) || $past(setupWritten)) else $error("cfg change");
  a_nack_free: assert property (masterNack |=> sdaOe_n [*4]) else $error("nack hold");
  a_taken_read: assert property (resultTaken |-> readActive && !masterNack)
    else $error("taken outside read");
endmodule
bind adc_two_wire_setup_slave adc_setup_monitor adc_setup_monitor_i (
  .clk(clk), .rst_n(rst_n), .ce(ce), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe_n(sdaOe_n), .sampleDiff(sampleDiff), .resultCode(resultCode),
  .resultTaken(resultTaken), .setupFields(setupFields), .configByte(configByte),
  .sharedInputRefIsRef(sharedInputRefIsRef), .inputEndedSelect(inputEndedSelect),
  .bipolarActive(bipolarActive), .setupWritten(setupWritten), .configWritten(configWritten),
  .busBusy(busBusy), .readActive(readActive), .masterNack(masterNack)
);

// ---- bench/bus_master_model.sv ----
`timescale 1ns/1ps
module bus_master_model (
  // clock
  input wire logic clk,
  // bus, sdaRel high releases the line
  input wire logic sdaLine,
  output logic scl,
  output logic sdaRel
);
  initial begin
    scl = 1'h1;
    sdaRel = 1'h1;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask
  // start or repeated start
  task automatic startC();
    hold(3);
    sdaRel = 1'h1;
    hold(7);
    scl = 1'h1;
    hold(10);
    sdaRel = 1'h0;
    hold(10);
    scl = 1'h0;
  endtask
  task automatic stopC();
    hold(3);
    sdaRel = 1'h0;
    hold(7);
    scl = 1'h1;
    hold(10);
    sdaRel = 1'h1;
    hold(10);
  endtask
  // sda moves only while scl is low
  task automatic bitC(input logic v, output logic s);
    hold(3);
    sdaRel = v;
    hold(7);
    scl = 1'h1;
    hold(5);
    s = sdaLine;
    hold(5);
    scl = 1'h0;
  endtask
  task automatic wrByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitC(b[i], s);
    end
    bitC(1'h1, ack);
  endtask
  task automatic rdByte(input logic ackIt, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitC(1'h1, s);
      b[i] = s;
    end
    bitC(!ackIt, s);
  endtask
endmodule

// ---- bench/test_adc_two_wire_setup_slave.sv ----
`timescale 1ns/1ps
module test_adc_two_wire_setup_slave;
  localparam logic [7:0] ADDR_W = {adc_setup_pkg::SLAVE_ADDR_DEFAULT, 1'h0};
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic ce = 1'h1;
  logic signed [8:0] sampleDiff = 9'sh000;
  logic scl, sdaRel, sdaOut, sdaOe_n, refPin, bipolarActive, busBusy, ack;
  logic [7:0] resultCode, configByte, rd;
  adc_setup_pkg::setup_t setupFields;
  wire sda = sdaRel & (sdaOe_n | sdaOut);
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  bus_master_model master_i (.clk(clk), .sdaLine(sda), .scl(scl), .sdaRel(sdaRel));
  adc_two_wire_setup_slave adc_two_wire_setup_slave_i (
    .clk(clk), .rst_n(rst_n), .ce(ce), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
    .sdaOe_n(sdaOe_n), .sampleDiff(sampleDiff), .resultCode(resultCode), .resultTaken(),
    .setupFields(setupFields), .sharedInputRefIsRef(refPin), .configByte(configByte),
    .inputEndedSelect(), .bipolarActive(bipolarActive), .setupWritten(), .configWritten(),
    .busBusy(busBusy), .readActive(), .masterNack()
  );
  task automatic final_report();
    if (err_total == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrAck(input logic [7:0] b, input logic e);
    master_i.wrByte(b, ack);
    chk({7'h0, ack}, {7'h0, e});
  endtask
  task automatic wr2(input logic [7:0] a, input logic [7:0] b);
    master_i.startC();
    wrAck(ADDR_W, 1'h0);
    wrAck(a, 1'h0);
    wrAck(b, 1'h0);
    master_i.stopC();
  endtask
  task automatic code(input logic signed [8:0] s, input logic [7:0] e);
    sampleDiff = s;
    repeat (3) @(negedge clk);
    chk(resultCode, e);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      final_report();
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'h1;
    repeat (4) @(negedge clk);
    chk({3'h0, setupFields}, 8'h00);
    chk(configByte, adc_setup_pkg::CFG_DEFAULT);
    chk({6'h0, sdaOe_n, busBusy}, 8'h02);
    code(-9'sd5, 8'h00);
    // wrong address is refused, then the transfer is retried
    master_i.startC();
    wrAck(ADDR_W ^ 8'h02, 1'h1);
    master_i.stopC();
    wr2(8'h00, 8'hFE);
    chk({3'h0, setupFields}, 8'h1F);
    chk(configByte, 8'h00);
    chk({7'h0, bipolarActive}, 8'h01);
    code(9'sd200, 8'h7F);
    code(-9'sd200, 8'h80);
    code(-9'sd3, 8'hFD);
    code(9'sd100, 8'h64);
    wr2(8'hAB, 8'h00);
    chk({3'h0, setupFields}, 8'h0A);
    code(-9'sd5, 8'h00);
    code(9'sd200, 8'hC8);
    // clock enable low freezes the result register
    ce = 1'h0;
    sampleDiff = -9'sd5;
    repeat (3) @(negedge clk);
    chk(resultCode, 8'hC8);
    ce = 1'h1;
    // setup with clear bit low, then repeated start into a read
    sampleDiff = 9'sd77;
    master_i.startC();
    wrAck(ADDR_W, 1'h0);
    wrAck(8'hA5, 1'h0);
    master_i.startC();
    chk({7'h0, busBusy}, 8'h01);
    wrAck(ADDR_W | 8'h01, 1'h0);
    master_i.rdByte(1'h1, rd);
    chk(rd, 8'h4D);
    master_i.rdByte(1'h0, rd);
    chk(rd, 8'h4D);
    repeat (4) @(negedge clk);
    chk({7'h0, sdaOe_n}, 8'h01);
    master_i.stopC();
    chk({7'h0, busBusy}, 8'h00);
    chk({3'h0, setupFields}, 8'h09);
    chk(configByte, 8'h01);
    chk({6'h0, refPin, bipolarActive}, 8'h02);
    final_report();
  end
endmodule
